// >>> hw/wprx_ctrl.v
// Purpose: Control and packet sequencer of an inductive power receiver.
// Assumes: Comparator and ADC inputs are synchronous to aclk.
// Notes:   Packet transmit is a valid/ready strobe to the modulator.
`timescale 1ns/1ps
`include "wprx_defs.vh"

module wprx_ctrl #(
  parameter [31:0] SURGE_CYC  = `WPRX_SURGE_CYC,
  parameter [31:0] STEADY_CYC = `WPRX_STEADY_CYC,
  parameter [31:0] LOOP_CYC   = `WPRX_LOOP_CYC
) (
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Analog comparator levels and ADC readings
  input  wire        ping_memory_high,
  input  wire        digital_ping,
  input  wire        temp_ctrl_high,
  input  wire        temp_ctrl_low,
  input  wire        hot_trip,
  input  wire        adapter_present,
  input  wire        input_surge,
  input  wire        rect_overvoltage,
  input  wire        internal_fault,
  input  wire [15:0] rect_mv,
  input  wire [6:0]  load_percent,
  // Packet transmitter
  output reg         pkt_valid,
  input  wire        pkt_ready,
  output reg  [7:0]  pkt_header,
  output reg  [7:0]  pkt_payload,
  // Power path and pins
  output reg         out_enable,
  output wire        pad_present_n_o,
  output wire        pad_present_n_oe,
  output wire        host_serial_en,
  output wire        irq
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_SIG  = 3'd1;
  localparam [2:0] ST_CFG  = 3'd2;
  localparam [2:0] ST_ID   = 3'd3;
  localparam [2:0] ST_RAMP = 3'd4;
  localparam [2:0] ST_ACT  = 3'd5;
  localparam [2:0] ST_EPT  = 3'd6;
  localparam [2:0] ST_OFF  = 3'd7;

  reg  [2:0]  state;
  reg  [31:0] ctrl;
  reg  [3:0]  irq_stat;
  reg  [3:0]  irq_en;
  reg  [15:0] target_mv;
  reg  [7:0]  ept_reason;
  reg  [31:0] tmr;
  reg         surge_mode;
  reg         after_surge;
  reg         ovp_seen;
  reg         pad_d;
  reg  [7:0]  next_hdr;
  reg  [7:0]  next_pay;
  reg  [7:0]  cep_err;
  reg         aw_hold;
  reg         w_hold;
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg  [3:0]  ev;

  wire pkt_done = pkt_valid & pkt_ready;
  wire enabled  = ctrl[`WPRX_CTRL_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // End-transfer condition priority, checked from more than one state

  function [8:0] ept_check;
    input adp;
    input flt;
    input hot;
    input tlow;
    input thigh;
    begin
      if (adp)
        ept_check = {1'b1, `WPRX_EPT_UNKNOWN};
      else if (flt)
        ept_check = {1'b1, `WPRX_EPT_FAULT};
      else if (hot || tlow)
        ept_check = {1'b1, `WPRX_EPT_HOT};
      else if (thigh)
        ept_check = {1'b1, `WPRX_EPT_CHARGED};
      else
        ept_check = 9'h000;
    end
  endfunction

  wire [8:0] ept_now = ept_check(adapter_present, internal_fault, hot_trip,
                                 temp_ctrl_low, temp_ctrl_high);

  // Error packet spacing: fast while surging, the slow steady pace after a
  // surge has passed and during the ramp, the loop rate otherwise
  wire [31:0] pace_cyc = surge_mode ? SURGE_CYC :
                         (after_surge || state != ST_ACT) ? STEADY_CYC :
                         LOOP_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // Pad detect open-drain pin: drive low only while memory node holds charge

  // Board pull-up supplies the high level while the pin is released
  assign pad_present_n_o  = 1'b0;
  assign pad_present_n_oe = ping_memory_high;
  // Serial host port exists only when the variant bit is set
  assign host_serial_en   = ctrl[`WPRX_CTRL_VARIANT_BIT];
  assign irq              = |(irq_stat & irq_en);

  ////////////////////////////////////////////////////////////////////////////
  // Control error from target; saturates to a signed byte

  // Low-byte difference is exact here since the error fits in a byte
  always @* begin
    if (rect_overvoltage || rect_mv > target_mv + 16'd127)
      cep_err = 8'h80;
    else if (target_mv > rect_mv + 16'd127)
      cep_err = 8'h7f;
    else
      cep_err = target_mv[7:0] - rect_mv[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: startup handshake, ramp, active loop, end transfer

  always @(posedge aclk) begin
    if (!aresetn) begin
      state       <= ST_IDLE;
      pkt_valid   <= 1'b0;
      pkt_header  <= 8'h00;
      pkt_payload <= 8'h00;
      out_enable  <= 1'b0;
      target_mv   <= `WPRX_V_STARTUP_MV;
      ept_reason  <= 8'h00;
      tmr         <= 32'h0;
      surge_mode  <= 1'b0;
      after_surge <= 1'b0;
      ovp_seen    <= 1'b0;
      ev          <= 4'h0;
    end else begin
      ev <= 4'h0;
      if (pkt_done) begin
        pkt_valid    <= 1'b0;
        ev[`WPRX_IRQ_PKT] <= 1'b1;
      end
      tmr <= tmr + 32'd1;
      case (state)
        ST_IDLE: begin
          out_enable <= 1'b0;
          // The transmitter's extended ping starts the handshake
          if (enabled && digital_ping) begin
            if (ept_now[8]) begin
              ept_reason <= ept_now[7:0];
              state      <= ST_EPT;
            end else
              state <= ST_SIG;
          end
        end
        // Valid falls for one cycle after each take, then the next is offered
        ST_SIG, ST_CFG, ST_ID: begin
          if (!pkt_valid && !pkt_done) begin
            pkt_valid   <= 1'b1;
            pkt_header  <= (state == ST_SIG) ? `WPRX_PKT_SIG :
                           (state == ST_CFG) ? `WPRX_PKT_CFG : `WPRX_PKT_ID;
            pkt_payload <= 8'h00;
          end else if (pkt_done) begin
            // Contract is held once identification is accepted
            state       <= state + 3'd1;
            tmr         <= 32'h0;
            target_mv   <= `WPRX_V_STARTUP_MV;
          end
        end
        ST_RAMP, ST_ACT: begin
          // Any end condition wins over regulation in every pass
          if (ept_now[8] || !enabled) begin
            ept_reason <= ept_now[8] ? ept_now[7:0] : `WPRX_EPT_UNKNOWN;
            out_enable <= 1'b0;
            // A packet already offered stays up until the transmitter takes it
            after_surge <= 1'b0;
            state      <= ST_EPT;
          end else begin
            if (state == ST_ACT)
              target_mv <= `WPRX_V_BASE_MV
                           - `WPRX_V_SLOPE_MV * {9'h000, load_percent};
            if (rect_overvoltage) begin
              out_enable <= 1'b0;
              ovp_seen   <= 1'b1;
              target_mv  <= `WPRX_V_STARTUP_MV;
            end else if (state == ST_RAMP && rect_mv >= `WPRX_V_STARTUP_MV
                         - 16'd200) begin
              out_enable <= 1'b1;
              state      <= ST_ACT;
            end else if (state == ST_ACT)
              out_enable <= 1'b1;
            // Surge/steady change restarts the packet timer
            if (input_surge != surge_mode) begin
              surge_mode <= input_surge;
              // Once a surge ends the steady pace holds until transfer ends
              if (surge_mode)
                after_surge <= 1'b1;
              tmr        <= 32'h0;
            end else if (!pkt_valid && tmr >= pace_cyc) begin
              pkt_valid   <= 1'b1;
              pkt_header  <= `WPRX_PKT_CEP;
              pkt_payload <= cep_err;
              tmr         <= 32'h0;
            end
          end
        end
        ST_EPT: begin
          out_enable <= 1'b0;
          if (!pkt_valid && !pkt_done) begin
            pkt_valid   <= 1'b1;
            pkt_header  <= `WPRX_PKT_EPT;
            pkt_payload <= ept_reason;
          end else if (pkt_done && pkt_header == `WPRX_PKT_EPT) begin
            // A loop packet still pending finishes first and is not counted
            ev[`WPRX_IRQ_EPT] <= 1'b1;
            state <= ST_OFF;
          end
        end
        ST_OFF: begin
          // Transmitter powers down; restart only once the ping ends
          if (!digital_ping)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      if (rect_overvoltage && !ovp_seen)
        ev[`WPRX_IRQ_OVP] <= 1'b1;
      if (!rect_overvoltage)
        ovp_seen <= 1'b0;
      if (pad_d != ping_memory_high)
        ev[`WPRX_IRQ_PAD] <= 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn)
      pad_d <= 1'b0;
    else
      pad_d <= ping_memory_high;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data captured in either order
  // Only one write and one read are ever outstanding, so no IDs are kept

  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'b00;
      s_axi_rdata  <= 32'h0;
      ctrl         <= `WPRX_CTRL_RESET;
      irq_en       <= 4'h0;
      irq_stat     <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // Set wins over a clear in the same cycle
      irq_stat <= irq_stat | ev;
      if (aw_hold && w_hold) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        case (aw_addr)
          `WPRX_REG_CTRL:
            if (w_strb[0]) ctrl[7:0] <= w_data[7:0];
          `WPRX_REG_IRQ_EN:
            if (w_strb[0]) irq_en <= w_data[3:0];
          `WPRX_REG_IRQ_CLR:
            if (w_strb[0]) irq_stat <= (irq_stat & ~w_data[3:0]) | ev;
          `WPRX_REG_STATUS, `WPRX_REG_IRQ_STAT,
          `WPRX_REG_TARGET, `WPRX_REG_LAST_PKT: ;
          default: s_axi_bresp <= 2'b10;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `WPRX_REG_CTRL:     s_axi_rdata <= {24'h0, ctrl[7:0]};
          `WPRX_REG_STATUS:   s_axi_rdata <= {24'h0, ept_reason[3:0],
                                  out_enable, state};
          `WPRX_REG_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat};
          `WPRX_REG_IRQ_EN:   s_axi_rdata <= {28'h0, irq_en};
          `WPRX_REG_IRQ_CLR:  s_axi_rdata <= 32'h0;
          `WPRX_REG_TARGET:   s_axi_rdata <= {16'h0, target_mv};
          `WPRX_REG_LAST_PKT: s_axi_rdata <= {16'h0, pkt_header, pkt_payload};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // wprx_ctrl

// >>> hw/wprx_defs.vh
// Purpose: Constants for the wireless power receiver control sequencer.
// Assumes: 100 MHz aclk; analog comparators arrive as synchronous levels.
// Notes:   Register offsets are byte addresses on an AXI4-Lite slave.
`ifndef WPRX_DEFS_VH
`define WPRX_DEFS_VH

// Register byte offsets
`define WPRX_REG_CTRL      8'h00
`define WPRX_REG_STATUS    8'h04
`define WPRX_REG_IRQ_STAT  8'h08
`define WPRX_REG_IRQ_EN    8'h0c
`define WPRX_REG_IRQ_CLR   8'h10
`define WPRX_REG_TARGET    8'h14
`define WPRX_REG_LAST_PKT  8'h18

// Control register fields
`define WPRX_CTRL_EN_BIT     0
`define WPRX_CTRL_VARIANT_BIT 1
`define WPRX_CTRL_RESET    32'h0000_0001

// Interrupt bit positions
`define WPRX_IRQ_PKT   0
`define WPRX_IRQ_EPT   1
`define WPRX_IRQ_OVP   2
`define WPRX_IRQ_PAD   3
`define WPRX_IRQ_W     4

// Packet headers
`define WPRX_PKT_SIG   8'h01
`define WPRX_PKT_EPT   8'h02
`define WPRX_PKT_CEP   8'h03
`define WPRX_PKT_ID    8'h71
`define WPRX_PKT_CFG   8'h51

// End transfer reasons
`define WPRX_EPT_UNKNOWN 8'h00
`define WPRX_EPT_CHARGED 8'h01
`define WPRX_EPT_FAULT   8'h02
`define WPRX_EPT_HOT     8'h03
`define WPRX_EPT_OVP     8'h04

// Timing
`define WPRX_CLK_MHZ       100
`define WPRX_T_SURGE_MS    30
`define WPRX_T_STEADY_MS   250
`define WPRX_T_LOOP_MS     32
`define WPRX_MS_CYC        (`WPRX_CLK_MHZ * 1000)
`define WPRX_SURGE_CYC     (`WPRX_T_SURGE_MS * `WPRX_MS_CYC)
`define WPRX_STEADY_CYC    (`WPRX_T_STEADY_MS * `WPRX_MS_CYC)
`define WPRX_LOOP_CYC      (`WPRX_T_LOOP_MS * `WPRX_MS_CYC)

// Rectifier targets in mV
`define WPRX_V_STARTUP_MV  16'd8000
`define WPRX_V_BASE_MV     16'd5000
`define WPRX_V_SLOPE_MV    16'd20

`endif

// >>> verification/tb.sv
// Purpose: Self-checking bench for the receiver sequencer.
// Assumes: Short packet timers set through parameters.
// Notes:   Tasks start on a rising edge and end on the falling edge, except getp, which ends on a rising edge.
`timescale 1ns/1ps
`include "wprx_defs.vh"
module tb;
  localparam SC = 50;
  localparam ST = 200;
  localparam LC = 80;
  localparam [39:0] RSN = 40'h0200030301;
  reg         aclk = 0, aresetn = 0, slow = 0, ping_req = 0;
  reg  [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  reg  [31:0] s_axi_wdata = 0, rd_v;
  reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg         s_axi_arvalid = 0, s_axi_rready = 0, ping_memory_high = 0;
  reg         temp_ctrl_high = 0, temp_ctrl_low = 0, hot_trip = 0;
  reg         adapter_present = 0, input_surge = 0, rect_overvoltage = 0;
  reg         internal_fault = 0;
  reg  [15:0] rect_mv = 0, pk, pq[$];
  reg  [6:0]  load_percent = 0;
  reg  [1:0]  rr, br;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, digital_ping, pkt_valid, pkt_ready, out_enable;
  wire        pad_present_n_o, pad_present_n_oe, host_serial_en, irq;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0]  pkt_header, pkt_payload;
  integer     fail_count = 0, tests_run = 0, cyc = 0, last_t = 0, gap = 0, i;
  wprx_ctrl #(.SURGE_CYC(SC), .STEADY_CYC(ST), .LOOP_CYC(LC)) dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ping_memory_high, .digital_ping,
    .temp_ctrl_high, .temp_ctrl_low, .hot_trip, .adapter_present,
    .input_surge, .rect_overvoltage, .internal_fault, .rect_mv,
    .load_percent, .pkt_valid, .pkt_ready, .pkt_header, .pkt_payload,
    .out_enable, .pad_present_n_o, .pad_present_n_oe, .host_serial_en, .irq);
  wprx_tx_model tx_u (.aclk, .aresetn, .ping_req, .slow, .pkt_valid,
    .pkt_header, .digital_ping, .pkt_ready);
  //////////////////////////////////////////////////////////////////////////
  // Clock, and a monitor that queues every packet taken
  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (pkt_valid && pkt_ready) begin
      pq.push_back({pkt_header, pkt_payload});
      if (pkt_header == `WPRX_PKT_CEP) begin
        gap    <= cyc - last_t;
        last_t <= cyc;
      end
    end
  end
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // Valid and payload stay put until the edge that finds ready high
  task wr(input [7:0] a, input [31:0] d);
    reg aw_ok, w_ok, b_ok;
    begin
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid,
       s_axi_bready} <= {a, d, 3'b111};
      b_ok = 0;
      while (!b_ok) begin
        @(negedge aclk);
        aw_ok = s_axi_awvalid & s_axi_awready;
        w_ok = s_axi_wvalid & s_axi_wready;
        {b_ok, br} = {s_axi_bvalid, s_axi_bresp};
        @(posedge aclk);
        if (aw_ok) s_axi_awvalid <= 1'b0;
        if (w_ok) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      @(negedge aclk);
    end
  endtask
  task rd(input [7:0] a);
    reg ar_ok, r_ok;
    begin
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
      r_ok = 0;
      while (!r_ok) begin
        @(negedge aclk);
        ar_ok = s_axi_arvalid & s_axi_arready;
        r_ok = s_axi_rvalid;
        {rd_v, rr} = {s_axi_rdata, s_axi_rresp};
        @(posedge aclk);
        if (ar_ok) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(negedge aclk);
    end
  endtask
  task rdc(input string nm, input [7:0] a, input [31:0] e);
    begin
      rd(a);
      chk(nm, e, rd_v);
      chk("rresp", 0, rr);
    end
  endtask
  task wt(input integer n);
    begin
      repeat (n) @(posedge aclk);
      @(negedge aclk);
    end
  endtask
  // Next packet, passing over control error packets when asked
  task getp(input skip);
    integer n;
    begin
      n = 0;
      pk = 16'hffff;
      while ((pk == 16'hffff || (skip && pk[15:8] == `WPRX_PKT_CEP))
             && n < 4000) begin
        @(posedge aclk);
        n = n + 1;
        if (pq.size() != 0) pk = pq.pop_front();
      end
      if (n >= 4000) chk("pkt_wait", 1, 0);
    end
  endtask
  task done_t(input string nm);
    $display("test %0s finished", nm);
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Main sequence; a hang is cut short by the watchdog below
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdc("ctrl", `WPRX_REG_CTRL, `WPRX_CTRL_RESET);
    rdc("irq_clr", `WPRX_REG_IRQ_CLR, 0);
    rd(8'h1c);
    chk("unmapped_resp", 2'b10, rr);
    chk("unmapped_data", 0, rd_v);
    wr(8'h1c, 32'h0);
    chk("unmapped_wr", 2'b10, br);
    wr(`WPRX_REG_CTRL, 32'h3);
    chk("serial_on", 1, host_serial_en);
    wr(`WPRX_REG_CTRL, 32'h1);
    chk("serial_off", 0, host_serial_en);
    done_t("registers");
    wr(`WPRX_REG_IRQ_EN, 32'h8);
    @(posedge aclk) ping_memory_high <= 1'b1;
    wt(2);
    chk("pad_oe", 1, pad_present_n_oe);
    chk("pad_o", 0, pad_present_n_o);
    chk("irq_pad", 1, irq);
    @(posedge aclk) ping_memory_high <= 1'b0;
    wt(2);
    chk("pad_rel", 0, pad_present_n_oe);
    rdc("irq_stat", `WPRX_REG_IRQ_STAT, 32'h8);
    wr(`WPRX_REG_IRQ_EN, 0);
    chk("irq_mask", 0, irq);
    wr(`WPRX_REG_IRQ_CLR, 32'h8);
    wr(`WPRX_REG_IRQ_EN, 32'h2);
    chk("irq_clr", 0, irq);
    done_t("pad_irq");
    @(posedge aclk) {slow, ping_req} <= 2'b11;
    getp(0);
    chk("pkt1", {`WPRX_PKT_SIG, 8'h00}, pk);
    getp(0);
    chk("pkt2", {`WPRX_PKT_CFG, 8'h00}, pk);
    getp(0);
    chk("pkt3", {`WPRX_PKT_ID, 8'h00}, pk);
    getp(0);
    chk("pkt4", `WPRX_PKT_CEP, pk[15:8]);
    rdc("ramp_target", `WPRX_REG_TARGET, 8000);
    chk("out_off", 0, out_enable);
    @(posedge aclk) rect_mv <= 16'd8000;
    for (i = 0; i < 3000 && out_enable !== 1'b1; i = i + 1) @(negedge aclk);
    chk("out_on", 1, out_enable);
    rdc("act_target0", `WPRX_REG_TARGET, 5000);
    @(posedge aclk) load_percent <= 7'd50;
    wt(4);
    rdc("act_target", `WPRX_REG_TARGET, 4000);
    done_t("startup");
    @(posedge aclk) {slow, input_surge} <= 2'b01;
    wt(LC + 3 * SC);
    chk("surge_gap", 1, gap >= SC - 1 && gap <= SC + 2);
    @(posedge aclk) {input_surge, rect_overvoltage} <= 2'b01;
    wt(3);
    chk("ovp_out", 0, out_enable);
    pq.delete();
    getp(0);
    chk("ovp_cep", {`WPRX_PKT_CEP, 8'h80}, pk);
    getp(0);
    wt(1);
    chk("steady_gap", 1, gap >= ST - 1 && gap <= ST + 2);
    @(posedge aclk) rect_overvoltage <= 1'b0;
    wt(1);
    chk("irq_ept0", 0, irq);
    @(posedge aclk) temp_ctrl_high <= 1'b1;
    getp(1);
    chk("ept_high", {`WPRX_PKT_EPT, `WPRX_EPT_CHARGED}, pk);
    wt(2);
    chk("irq_ept", 1, irq);
    rdc("last_pkt", `WPRX_REG_LAST_PKT, {`WPRX_PKT_EPT, `WPRX_EPT_CHARGED});
    @(posedge aclk) {temp_ctrl_high, ping_req} <= 2'b00;
    wr(`WPRX_REG_IRQ_CLR, 32'h2);
    chk("irq_ept_clr", 0, irq);
    done_t("active");
    // Each end condition already present when the ping arrives
    for (i = 0; i < 5; i = i + 1) begin
      @(posedge aclk) {internal_fault, adapter_present, hot_trip,
                       temp_ctrl_low, temp_ctrl_high} <= 5'd1 << i;
      @(posedge aclk) ping_req <= 1'b1;
      getp(0);
      chk("ept_start", {`WPRX_PKT_EPT, RSN[8*i +: 8]}, pk);
      @(posedge aclk) {internal_fault, adapter_present, hot_trip,
                       temp_ctrl_low, temp_ctrl_high, ping_req} <= 6'd0;
      wt(4);
    end
    done_t("shutdown");
    summarize;
  end
  initial begin
    #400000;
    fail_count = fail_count + 1;
    summarize;
  end
endmodule // tb
bind wprx_ctrl wprx_ctrl_properties chk_u (.aclk, .aresetn,
  .ping_memory_high, .rect_overvoltage, .rect_mv, .pkt_valid, .pkt_ready,
  .pkt_header, .pkt_payload, .out_enable, .pad_present_n_o,
  .pad_present_n_oe, .s_axi_bvalid, .s_axi_awready, .s_axi_rvalid,
  .s_axi_arready);

// >>> verification/wprx_ctrl_properties.sv
// Purpose: Temporal checks on the receiver sequencer ports.
// Assumes: One aclk domain, synchronous active-low reset.
// Notes:   Bound to wprx_ctrl from the testbench top file.
`timescale 1ns/1ps
`include "wprx_defs.vh"
module wprx_ctrl_properties (
  input wire        aclk,
  input wire        aresetn,
  input wire        ping_memory_high,
  input wire        rect_overvoltage,
  input wire [15:0] rect_mv,
  input wire        pkt_valid,
  input wire        pkt_ready,
  input wire [7:0]  pkt_header,
  input wire [7:0]  pkt_payload,
  input wire        out_enable,
  input wire        pad_present_n_o,
  input wire        pad_present_n_oe,
  input wire        s_axi_bvalid,
  input wire        s_axi_awready,
  input wire        s_axi_rvalid,
  input wire        s_axi_arready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////
  // Handshake steps: one packet taken, the next one offered soon after
  sequence s_take(logic [7:0] h);
    pkt_valid && pkt_ready && pkt_header == h;
  endsequence
  sequence s_offer(logic [7:0] h);
    ##[1:8] (pkt_valid && pkt_header == h);
  endsequence
  property p_pad_low;
    ping_memory_high |-> pad_present_n_oe && !pad_present_n_o;
  endproperty
  property p_pad_rel;
    !ping_memory_high |-> !pad_present_n_oe;
  endproperty
  property p_pkt_hold;
    pkt_valid && !pkt_ready |=>
      pkt_valid && $stable(pkt_header) && $stable(pkt_payload);
  endproperty
  property p_sig_cfg;
    s_take(`WPRX_PKT_SIG) |-> s_offer(`WPRX_PKT_CFG);
  endproperty
  property p_cfg_id;
    s_take(`WPRX_PKT_CFG) |-> s_offer(`WPRX_PKT_ID);
  endproperty
  property p_ovp_off;
    $rose(rect_overvoltage) |-> ##[1:2] !out_enable;
  endproperty
  property p_en_ramp;
    $rose(out_enable) |-> $past(rect_mv) >= 16'd7800;
  endproperty
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_pad_low: assert property (p_pad_low)
    else $error("pad pin not pulled low");
  a_pad_rel: assert property (p_pad_rel)
    else $error("pad pin not released");
  a_pkt_hold: assert property (p_pkt_hold)
    else $error("packet changed before taken");
  a_sig_cfg: assert property (p_sig_cfg)
    else $error("configuration packet missing");
  a_cfg_id: assert property (p_cfg_id)
    else $error("identification packet missing");
  a_ovp_off: assert property (p_ovp_off)
    else $error("regulator kept on in overvoltage");
  a_en_ramp: assert property (p_en_ramp)
    else $error("output enabled before ramp done");
  a_aw_block: assert property (p_aw_block)
    else $error("write address taken during response");
  a_ar_block: assert property (p_ar_block)
    else $error("read address taken during response");
endmodule // wprx_ctrl_properties

// >>> verification/wprx_tx_model.sv
// Purpose: Behavioural transmitter facing the receiver sequencer.
// Assumes: Packets arrive as a valid/ready strobe in the aclk domain.
// Notes:   Slow mode halves the accept rate to stress held packets.
`timescale 1ns/1ps
`include "wprx_defs.vh"
module wprx_tx_model (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       ping_req,
  input  wire       slow,
  input  wire       pkt_valid,
  input  wire [7:0] pkt_header,
  output reg        digital_ping,
  output reg        pkt_ready
);
  reg  stopped;
  wire ept_taken = pkt_valid && pkt_ready && pkt_header == `WPRX_PKT_EPT;
  //////////////////////////////////////////////////////////////////////////
  // An end packet stops power until the object is lifted and set down
  always @(posedge aclk) begin
    if (!aresetn) begin
      digital_ping <= 1'b0;
      pkt_ready    <= 1'b0;
      stopped      <= 1'b0;
    end else begin
      pkt_ready    <= slow ? ~pkt_ready : 1'b1;
      stopped      <= ept_taken | (stopped & ping_req);
      digital_ping <= ping_req & ~stopped & ~ept_taken;
    end
  end
endmodule // wprx_tx_model
